// ---- rtl/alu_instruction_subset.sv ----
// Instruction subset executor with accumulator, status, file registers
// and watchdog counter, all reached over APB.
// Assumes a well-behaved APB master on the same clock as the block.
//
// Operation
// RULE1 - Rotate file register right through carry
// RULE2 - Destination bit picks accumulator or file
// RULE3 - Sleep clears watchdog counter and prescaler
// RULE4 - Sleep clears power-down flag, sets time-out flag
// RULE5 - Literal minus accumulator into accumulator
// RULE6 - File minus accumulator, routed by destination
// RULE7 - Subtracts set carry, nibble carry, zero
// RULE8 - XOR literal into accumulator, zero only
// RULE9 - XOR file with accumulator, routed by destination
// RULE10 - Old carry enters bit 7, bit 0 out
// RULE11 - Zero flag follows result equal zero
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

module alu_instruction_subset #(
	parameter int PRESC_DIV = alu_subset_pkg::PRESC_DIV
) (
	input  wire logic                              clk,
	input  wire logic                              sys_rst,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [alu_subset_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	output logic                                   sleep_entered_flag_n,
	output logic                                   watchdog_expired_flag_n
);

	// ********************************************************************
	// State
	// ********************************************************************
	// Prescaler divides exactly for any PRESC_DIV of 2 or more: it restarts from zero on the tick
	localparam int PRESC_W = $clog2(PRESC_DIV);

	logic [7:0]                  acc_r;
	alu_subset_pkg::status_t     status_r;
	logic [7:0]                  file_mem [alu_subset_pkg::FILE_DEPTH];
	logic [7:0]                  wdog_r;
	logic [PRESC_W-1:0]          presc_r;
	logic [31:0]                 prdata_r;
	logic                        pready_r;
	logic                        pslverr_r;

	// ********************************************************************
	// Address decode
	// ********************************************************************
	function automatic logic is_file(
		input logic [alu_subset_pkg::ADDR_W-1:0] a
	);
		is_file = (a[11:9] == alu_subset_pkg::FILE_SEL);
	endfunction : is_file

	function automatic logic is_mapped(
		input logic [alu_subset_pkg::ADDR_W-1:0] a
	);
		is_mapped = is_file(a) ||
			(a == alu_subset_pkg::CMD_OFS) ||
			(a == alu_subset_pkg::ACC_OFS) ||
			(a == alu_subset_pkg::STATUS_OFS) ||
			(a == alu_subset_pkg::WDOG_OFS);
	endfunction : is_mapped

	logic       access_end;
	logic       wr_fire;
	logic [6:0] file_idx;

	// Writes land only at the edge where pready is seen high
	assign access_end = psel && penable && pready_r;
	assign wr_fire    = access_end && pwrite && is_mapped(paddr);
	assign file_idx   = paddr[8:2];

	// ********************************************************************
	// Write strobes
	// ********************************************************************
	// Strobes fire once per access, at the answer edge
	logic acc_wr;
	logic status_wr;
	logic file_wr;

	assign acc_wr    = wr_fire && (paddr == alu_subset_pkg::ACC_OFS);
	assign status_wr = wr_fire && (paddr == alu_subset_pkg::STATUS_OFS);
	assign file_wr   = wr_fire && is_file(paddr);

	// ********************************************************************
	// Instruction execute
	// ********************************************************************
	alu_subset_pkg::cmd_t    cmd;
	alu_subset_pkg::status_t st_nxt;
	logic                    exec;
	logic [7:0]              f_val;
	logic [7:0]              minuend;
	logic [8:0]              diff9;
	logic [4:0]              diff5;
	logic [7:0]              res;
	logic                    to_acc;
	logic                    to_file;
	logic                    sleep_exec;

	assign cmd   = alu_subset_pkg::cmd_t'(pwdata);
	assign exec  = wr_fire && (paddr == alu_subset_pkg::CMD_OFS);
	assign f_val = file_mem[cmd.addr];

	// Borrow out of bit 8 and bit 4 gives both carries
	assign minuend = (cmd.op == alu_subset_pkg::literal_minus_acc_op) ?
		cmd.literal : f_val;
	assign diff9 = {1'b0, minuend} - {1'b0, acc_r};
	assign diff5 = {1'b0, minuend[3:0]} - {1'b0, acc_r[3:0]};

	// Shared by both subtracts so their flags cannot drift apart
	function automatic alu_subset_pkg::status_t sub_flags(
		input alu_subset_pkg::status_t s,
		input logic [8:0]              d9,
		input logic [4:0]              d5
	);
		alu_subset_pkg::status_t f;
		f                   = s;
		f.carry_flag        = !d9[8]; // [RULE7]
		f.nibble_carry_flag = !d5[4]; // [RULE7]
		f.zero_flag         = (d9[7:0] == 8'h00); // [RULE11]
		return f;
	endfunction : sub_flags

	always_comb begin
		res        = 8'h00;
		st_nxt     = status_r;
		to_acc     = 1'b0;
		to_file    = 1'b0;
		sleep_exec = 1'b0;
		unique case (cmd.op)
			alu_subset_pkg::rotate_right_carry_op: begin
				res               = {status_r.carry_flag, f_val[7:1]}; // [RULE1] [RULE10]
				st_nxt.carry_flag = f_val[0]; // [RULE10]
				to_acc            = !cmd.dest; // [RULE2]
				to_file           = cmd.dest; // [RULE2]
			end
			alu_subset_pkg::literal_minus_acc_op: begin
				res    = diff9[7:0]; // [RULE5]
				st_nxt = sub_flags(status_r, diff9, diff5); // [RULE7]
				to_acc = 1'b1; // [RULE5]
			end
			alu_subset_pkg::file_minus_acc_op: begin
				res     = diff9[7:0]; // [RULE6]
				st_nxt  = sub_flags(status_r, diff9, diff5); // [RULE7]
				to_acc  = !cmd.dest; // [RULE2] [RULE6]
				to_file = cmd.dest; // [RULE2] [RULE6]
			end
			alu_subset_pkg::xor_literal_op: begin
				res              = acc_r ^ cmd.literal; // [RULE8]
				st_nxt.zero_flag = ((acc_r ^ cmd.literal) == 8'h00); // [RULE8] [RULE11]
				to_acc           = 1'b1; // [RULE8]
			end
			alu_subset_pkg::xor_file_op: begin
				res              = acc_r ^ f_val; // [RULE9]
				st_nxt.zero_flag = ((acc_r ^ f_val) == 8'h00); // [RULE11]
				to_acc           = !cmd.dest; // [RULE2] [RULE9]
				to_file          = cmd.dest; // [RULE2] [RULE9]
			end
			alu_subset_pkg::sleep_op: begin
				st_nxt.sleep_entered_flag_n    = 1'b0; // [RULE4]
				st_nxt.watchdog_expired_flag_n = 1'b1; // [RULE4]
				sleep_exec                     = 1'b1; // [RULE3]
			end
			alu_subset_pkg::no_op: begin
				res = 8'h00;
			end
			// Spare op codes do nothing
			default: begin
				res = 8'h00;
			end
		endcase
	end

	// ********************************************************************
	// Accumulator
	// ********************************************************************
	// Execute and bus write never meet: one transfer at a time
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			acc_r <= alu_subset_pkg::ACC_RST;
		end else if (exec && to_acc) begin
			acc_r <= res; // [RULE2]
		end else if (acc_wr) begin
			acc_r <= pwdata[7:0];
		end
	end

	// ********************************************************************
	// File registers
	// ********************************************************************
	// No reset: data memory content is undefined until written
	always_ff @(posedge clk) begin
		if (exec && to_file) begin
			file_mem[cmd.addr] <= res; // [RULE2]
		end else if (file_wr) begin
			file_mem[file_idx] <= pwdata[7:0];
		end
	end

	// ********************************************************************
	// Watchdog counter and prescaler
	// ********************************************************************
	logic presc_tick;
	logic wdog_overflow;

	assign presc_tick    = (presc_r == PRESC_W'(PRESC_DIV - 1));
	// Sleep beats the wrap: the count restarts from zero
	assign wdog_overflow = presc_tick && !sleep_exec &&
		(wdog_r == alu_subset_pkg::WDOG_LAST);

	always_ff @(posedge clk) begin
		if (sys_rst || sleep_exec) begin
			presc_r <= '0; // [RULE3]
		end else if (presc_tick) begin
			presc_r <= '0;
		end else begin
			presc_r <= presc_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || sleep_exec) begin
			wdog_r <= alu_subset_pkg::WDOG_CLEAR; // [RULE3]
		end else if (presc_tick) begin
			wdog_r <= wdog_r + 8'h01;
		end
	end

	// ********************************************************************
	// Status
	// ********************************************************************
	// Time-out and power-down bits are read-only to software
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_r <= alu_subset_pkg::STATUS_RST;
		end else begin
			if (exec) begin
				status_r <= st_nxt; // [RULE4] [RULE7]
			end else if (status_wr) begin
				status_r.carry_flag <= pwdata[alu_subset_pkg::CARRY_BIT];
				status_r.nibble_carry_flag <=
					pwdata[alu_subset_pkg::NIBBLE_BIT];
				status_r.zero_flag <= pwdata[alu_subset_pkg::ZERO_BIT];
			end
			// Expiry is set last; wdog_overflow is gated off by a sleep, so no clear meets it
			if (wdog_overflow) begin
				status_r.watchdog_expired_flag_n <= 1'b0;
			end
		end
	end

	// ********************************************************************
	// APB slave
	// ********************************************************************
	function automatic logic [31:0] read_mux(
		input logic [alu_subset_pkg::ADDR_W-1:0] a
	);
		read_mux = alu_subset_pkg::RD_ZERO;
		if (is_file(a)) begin
			read_mux[7:0] = file_mem[a[8:2]];
		end else if (a == alu_subset_pkg::ACC_OFS) begin
			read_mux[7:0] = acc_r;
		end else if (a == alu_subset_pkg::STATUS_OFS) begin
			read_mux[4:0] = status_r;
		end else if (a == alu_subset_pkg::WDOG_OFS) begin
			read_mux[7:0] = wdog_r;
		end
	endfunction : read_mux

	logic [31:0] rd_word;

	// Writes answer zero so stale read data never leaks
	assign rd_word = pwrite ? alu_subset_pkg::RD_ZERO : read_mux(paddr);

	// One wait state keeps prdata straight from a flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= alu_subset_pkg::RD_ZERO;
		end else if (psel && penable && !pready_r) begin
			pready_r  <= 1'b1;
			pslverr_r <= !is_mapped(paddr);
			prdata_r  <= rd_word;
		end else begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	assign prdata                  = prdata_r;
	assign pready                  = pready_r;
	assign pslverr                 = pslverr_r;
	assign sleep_entered_flag_n    = status_r.sleep_entered_flag_n;
	assign watchdog_expired_flag_n = status_r.watchdog_expired_flag_n;

endmodule : alu_instruction_subset

// ---- rtl/alu_subset_pkg.sv ----
// Constants, command layout and status layout of the instruction subset.
// Assumes a single 100 MHz clock and an APB master with 32-bit data.
package alu_subset_pkg;

	// ********************************************************************
	// Register map (byte addresses)
	// ********************************************************************
	localparam int          ADDR_W     = 12;
	localparam logic [11:0] CMD_OFS    = 12'h000;
	localparam logic [11:0] ACC_OFS    = 12'h004;
	localparam logic [11:0] STATUS_OFS = 12'h008;
	localparam logic [11:0] WDOG_OFS   = 12'h00C;
	localparam logic [11:0] FILE_BASE  = 12'h200;
	localparam logic [2:0]  FILE_SEL   = 3'h1;
	localparam int          FILE_DEPTH = 128;

	// ********************************************************************
	// Reset and clear values
	// ********************************************************************
	localparam logic [7:0]  ACC_RST    = 8'h00;
	localparam logic [7:0]  WDOG_CLEAR = 8'h00;
	localparam logic [7:0]  WDOG_LAST  = 8'hFF;
	localparam int          PRESC_DIV  = 256;
	localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

	// ********************************************************************
	// Status field positions
	// ********************************************************************
	localparam int CARRY_BIT   = 0;
	localparam int NIBBLE_BIT  = 1;
	localparam int ZERO_BIT    = 2;
	localparam int SLEEP_BIT   = 3;
	localparam int EXPIRED_BIT = 4;

	// ********************************************************************
	// Types
	// ********************************************************************
	typedef enum logic [2:0] {
		no_op                 = 3'b000,
		rotate_right_carry_op = 3'b001,
		literal_minus_acc_op  = 3'b010,
		file_minus_acc_op     = 3'b011,
		xor_literal_op        = 3'b100,
		xor_file_op           = 3'b101,
		sleep_op              = 3'b110
	} op_t;

	typedef struct packed {
		logic [7:0] rsv_hi;
		logic [7:0] literal;
		logic       rsv_a;
		logic [6:0] addr;
		logic [3:0] rsv_b;
		logic       dest;
		op_t        op;
	} cmd_t;

	typedef struct packed {
		logic watchdog_expired_flag_n;
		logic sleep_entered_flag_n;
		logic zero_flag;
		logic nibble_carry_flag;
		logic carry_flag;
	} status_t;

	localparam status_t STATUS_RST = 5'h18;

endpackage : alu_subset_pkg

// ---- verification/alu_instruction_subset_test.sv ----
// Self-checking bench for the instruction subset block.
// Assumes the checker is bound; prescaler shortened to 4.
`timescale 1ns/100ps
module alu_instruction_subset_test;
	logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pready, pslverr, er, slp_n, exp_n;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int          n_errors = 0, cmp_count = 0;
	always #5 clk = ~clk;
	alu_instruction_subset #(.PRESC_DIV(4)) dut (.clk(clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_entered_flag_n(slp_n),
		.watchdog_expired_flag_n(exp_n));
	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Request held until pready is seen high at a rising edge
	task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : xfer
	task automatic wr(logic [11:0] a, logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rdc(string nm, logic [11:0] a, logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rdc
	function automatic logic [11:0] fa(logic [6:0] i);
		return alu_subset_pkg::FILE_BASE + {3'h0, i, 2'b00};
	endfunction : fa
	task automatic ex(logic [2:0] op, logic d, logic [6:0] f, logic [7:0] k);
		wr(alu_subset_pkg::CMD_OFS, {8'h00, k, 1'b0, f, 4'h0, d, op});
	endtask : ex
	task automatic acc(logic [31:0] e);
		rdc("acc", alu_subset_pkg::ACC_OFS, e);
	endtask : acc
	task automatic st(logic [31:0] e);
		rdc("status", alu_subset_pkg::STATUS_OFS, e);
	endtask : st
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_xor_lit;
		wr(alu_subset_pkg::ACC_OFS, 32'h5A);
		wr(alu_subset_pkg::STATUS_OFS, 32'h01);
		ex(alu_subset_pkg::xor_literal_op, 1'b0, 7'h00, 8'h5A);
		acc(32'h00);
		st(32'h1D);
		ex(alu_subset_pkg::xor_literal_op, 1'b0, 7'h00, 8'h0F);
		acc(32'h0F);
		st(32'h19);
	endtask : t_xor_lit
	task automatic t_sub_lit;
		wr(alu_subset_pkg::ACC_OFS, 32'h05);
		ex(alu_subset_pkg::literal_minus_acc_op, 1'b0, 7'h00, 8'h03);
		acc(32'hFE);
		st(32'h18);
		wr(alu_subset_pkg::ACC_OFS, 32'h03);
		ex(alu_subset_pkg::literal_minus_acc_op, 1'b0, 7'h00, 8'h03);
		acc(32'h00);
		st(32'h1F);
		wr(alu_subset_pkg::ACC_OFS, 32'h01);
		ex(alu_subset_pkg::literal_minus_acc_op, 1'b0, 7'h00, 8'hFF);
		acc(32'hFE);
		st(32'h1B);
	endtask : t_sub_lit
	task automatic t_sub_file;
		wr(fa(7'h7F), 32'h10);
		wr(alu_subset_pkg::ACC_OFS, 32'h01);
		ex(alu_subset_pkg::file_minus_acc_op, 1'b1, 7'h7F, 8'h00);
		rdc("file", fa(7'h7F), 32'h0F);
		acc(32'h01);
		st(32'h19);
		ex(alu_subset_pkg::file_minus_acc_op, 1'b0, 7'h7F, 8'h00);
		acc(32'h0E);
		rdc("file", fa(7'h7F), 32'h0F);
		st(32'h1B);
	endtask : t_sub_file
	task automatic t_rotate;
		wr(fa(7'h00), 32'h02);
		wr(alu_subset_pkg::STATUS_OFS, 32'h07);
		ex(alu_subset_pkg::rotate_right_carry_op, 1'b0, 7'h00, 8'h00);
		acc(32'h81);
		st(32'h1E);
		ex(alu_subset_pkg::rotate_right_carry_op, 1'b1, 7'h00, 8'h00);
		rdc("file", fa(7'h00), 32'h01);
		ex(alu_subset_pkg::rotate_right_carry_op, 1'b1, 7'h00, 8'h00);
		rdc("file", fa(7'h00), 32'h00);
		st(32'h1F);
	endtask : t_rotate
	task automatic t_xor_file;
		wr(fa(7'h05), 32'h0F);
		wr(alu_subset_pkg::ACC_OFS, 32'hF0);
		wr(alu_subset_pkg::STATUS_OFS, 32'h04);
		ex(alu_subset_pkg::xor_file_op, 1'b1, 7'h05, 8'h00);
		rdc("file", fa(7'h05), 32'hFF);
		st(32'h18);
		ex(alu_subset_pkg::xor_file_op, 1'b0, 7'h05, 8'h00);
		acc(32'h0F);
	endtask : t_xor_file
	task automatic t_sleep;
		for (int i = 0; i < 1100 && exp_n !== 1'b0; i++) @(posedge clk);
		chk("expired", 32'h0, {31'h0, exp_n});
		wr(alu_subset_pkg::STATUS_OFS, 32'h05);
		wr(alu_subset_pkg::WDOG_OFS, 32'h55);
		ex(alu_subset_pkg::sleep_op, 1'b0, 7'h00, 8'h00);
		chk("flags", 32'h1, {30'h0, slp_n, exp_n});
		rdc("wdog", alu_subset_pkg::WDOG_OFS, 32'h0);
		st(32'h15);
		xfer(1'b0, 12'h010, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
	endtask : t_sleep
	// ****************************************
	// Sequence and verdict
	// ****************************************
	task automatic finish_test;
		if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		st(32'h18);
		t_xor_lit();
		t_sub_lit();
		t_sub_file();
		t_rotate();
		t_xor_file();
		t_sleep();
		finish_test();
	end
	// Generous: the run needs about 1100 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		finish_test();
	end
endmodule : alu_instruction_subset_test

// ---- verification/alu_subset_asserts.sv ----
// Port checks for the instruction subset block.
// Assumes a bind onto alu_instruction_subset, one clock, sync reset.
`timescale 1ns/100ps
module alu_subset_asserts (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sleep_entered_flag_n,
	input wire logic        watchdog_expired_flag_n
);
	// ****************************************
	// Helpers
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic sleep_wr;
	assign sleep_wr = psel && penable && pready && pwrite &&
		paddr == alu_subset_pkg::CMD_OFS && pwdata[2:0] == 3'h6;
	sequence access_s(logic [11:0] a);
		psel && penable && !pready && paddr == a;
	endsequence
	sequence sleep_s;
		sleep_wr;
	endsequence
	// ****************************************
	// Assertions
	// ****************************************
	ready_one_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	unmapped_err_a: assert property (access_s(12'h010) |=>
		pslverr && prdata == 32'h0000_0000) else $error("no error");
	mapped_ok_a: assert property (access_s(alu_subset_pkg::ACC_OFS) |=>
		!pslverr) else $error("bad error");
	sleep_flags_a: assert property (
		sleep_s |=> !sleep_entered_flag_n && watchdog_expired_flag_n)
		else $error("sleep flags wrong");
	expired_set_a: assert property (
		$rose(watchdog_expired_flag_n) |-> $past(sleep_wr))
		else $error("expired flag set");
	sleep_hold_a: assert property (
		$rose(sleep_entered_flag_n) |-> $past(sys_rst))
		else $error("sleep flag rose");
	wdog_clear_a: assert property (
		sleep_s ##[1:3] access_s(alu_subset_pkg::WDOG_OFS) ##0 !pwrite
		|=> prdata == 32'h0000_0000) else $error("watchdog kept");
endmodule : alu_subset_asserts

bind alu_instruction_subset alu_subset_asserts chk_i (.clk(clk),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sleep_entered_flag_n(sleep_entered_flag_n),
	.watchdog_expired_flag_n(watchdog_expired_flag_n));
